// ### tbts_pkg.sv
// tbts_pkg: constants and carrier types of the timebase trigger synchronizer.
// assumes one clock_in tick stands for one period of the 10 GHz sample clock.
package tbts_pkg;
   // clock frequencies in MHz
   localparam int SAMPLE_FREQ_MHZ = 10000;
   localparam int TB_FREQ_MHZ     = 1000;
   localparam int REF_FREQ_MHZ    = 250;
   // sample ticks per timebase period, timebase periods per reference period
   localparam int TB_DIV          = SAMPLE_FREQ_MHZ / TB_FREQ_MHZ;
   localparam int REF_DIV         = TB_FREQ_MHZ / REF_FREQ_MHZ;
   localparam int TB_HIGH         = TB_DIV / 2;
   localparam int TB_CNT_W        = $clog2(TB_DIV);
   localparam int REF_CNT_W       = $clog2(REF_DIV);
   // digitizer clock copies and reference clock copies
   localparam int DIG_COPIES      = 4;
   localparam int REF_COPIES      = 4;
   localparam int CAL_COPY        = 3;
   localparam int PHASE_W         = 2;
   localparam int INTERP_W        = 2;

   // clock outputs of the block
   typedef struct packed {
      logic [DIG_COPIES-1:0] digitizer_clock;
      logic                  timebase_clock;
      logic [REF_COPIES-1:0] reference_quarter_clock;
   } tbts_clocks_t;

   // trigger outputs of the block
   typedef struct packed {
      logic                timebase_trigger_pulse;
      logic                reference_trigger_pulse;
      logic [PHASE_W-1:0]  phase_code;
      logic [INTERP_W-1:0] interp_msb;
   } tbts_trig_t;
endpackage

// ### tbts_mod_counter.sv
// tbts_mod_counter: modulo counter used for each division stage.
// assumes step_in is synchronous to clock_in.
module tbts_mod_counter #(
   parameter int MOD = 10,
   parameter int W   = 4
) (
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   input  wire logic         step_in,
   output logic [W-1:0]      count_out,
   output logic [W-1:0]      count_nxt_out,
   output logic              wrap_out
);
   logic [W-1:0] count_ff;
   logic [W-1:0] nxt_count;

   // next count, wrapping at MOD
   always_comb begin
      wrap_out  = step_in && (count_ff == W'(MOD - 1));
      nxt_count = count_ff;
      if (wrap_out) begin
         nxt_count = '0;
      end else if (step_in) begin
         nxt_count = count_ff + W'(1);
      end
   end

   // count register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign count_out     = count_ff;
   assign count_nxt_out = nxt_count;
endmodule

// ### tbts_core.sv
// tbts_core: timebase clock divider and trigger synchronizer.
// assumes clock_in is the sample clock; system_trigger_in is asynchronous.
// Function
// - divide sample clock into 1 GHz, 250 MHz
// - digitizer clocks pass only while run gated
// - reference clock is timebase divided by four
// - four reference copies in quadrature phase
// - calibrator reference copy off when unused
// - trigger resynchronised with two-flop synchroniser
// - one timebase trigger pulse per rising edge
// - one reference trigger pulse per rising edge
// - gate and reference trigger keep fixed reference phase
// - two-bit phase code from 500/250 MHz
// - trigger interpolation two MSBs from timebase
module tbts_core
   import tbts_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   input  wire logic              system_trigger_in,
   input  wire logic              digitizer_run_gate_in,
   input  wire logic              calibrator_enable_in,
   output tbts_pkg::tbts_clocks_t clocks_out,
   output tbts_pkg::tbts_trig_t   trig_out
);
   import tbts_pkg::*;

   // checks below run on the sample clock and, except a_reset_quiet, rest while reset is held
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   logic [TB_CNT_W-1:0]   tb_cnt;
   logic [TB_CNT_W-1:0]   tb_cnt_nxt;
   logic                  tb_wrap;
   logic [REF_CNT_W-1:0]  q_cnt;
   logic [REF_CNT_W-1:0]  q_cnt_nxt;
   logic                  q_wrap;
   logic                  ref_bound;

   // divider chain: sample -> timebase -> reference
   tbts_mod_counter #(.MOD(TB_DIV), .W(TB_CNT_W)) u_tb_div (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .step_in       (1'b1),
      .count_out     (tb_cnt),
      .count_nxt_out (tb_cnt_nxt),
      .wrap_out      (tb_wrap)
   );

   tbts_mod_counter #(.MOD(REF_DIV), .W(REF_CNT_W)) u_ref_div (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .step_in       (tb_wrap),
      .count_out     (q_cnt),
      .count_nxt_out (q_cnt_nxt),
      .wrap_out      (q_wrap)
   );

   assign ref_bound = q_wrap;

   // clock generation state
   logic                  tb_clk_ff,   nxt_tb_clk;
   logic [REF_COPIES-1:0] ref_clk_ff,  nxt_ref_clk;
   logic [DIG_COPIES-1:0] dig_clk_ff,  nxt_dig_clk;
   logic                  run_gate_ff, nxt_run_gate;
   logic                  cal_gate_ff, nxt_cal_gate;

   // clock levels follow the next divider phase so they align with the pulses
   always_comb begin
      logic [REF_CNT_W-1:0] ph;
      ph           = '0;
      nxt_tb_clk   = (tb_cnt_nxt < TB_CNT_W'(TB_HIGH));
      nxt_run_gate = ref_bound ? digitizer_run_gate_in : run_gate_ff;
      nxt_cal_gate = ref_bound ? calibrator_enable_in : cal_gate_ff;
      for (int k = 0; k < REF_COPIES; k++) begin
         ph             = q_cnt_nxt - REF_CNT_W'(k);
         nxt_ref_clk[k] = !ph[REF_CNT_W-1];
      end
      nxt_ref_clk[CAL_COPY] = nxt_ref_clk[CAL_COPY] && nxt_cal_gate;
      nxt_dig_clk = {DIG_COPIES{nxt_tb_clk && nxt_run_gate}};
   end

   // clock registers
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tb_clk_ff   <= 1'b0;
         ref_clk_ff  <= '0;
         dig_clk_ff  <= '0;
         run_gate_ff <= 1'b0;
         cal_gate_ff <= 1'b0;
      end else begin
         tb_clk_ff   <= nxt_tb_clk;
         ref_clk_ff  <= nxt_ref_clk;
         dig_clk_ff  <= nxt_dig_clk;
         run_gate_ff <= nxt_run_gate;
         cal_gate_ff <= nxt_cal_gate;
      end
   end

   // trigger state
   logic                sync1_ff, sync2_ff, sync3_ff;
   logic                trig_rise;
   logic                pend_tb_ff,  nxt_pend_tb;
   logic                pend_ref_ff, nxt_pend_ref;
   logic                tb_pulse_ff, nxt_tb_pulse;
   logic                ref_pulse_ff, nxt_ref_pulse;
   logic [PHASE_W-1:0]  phase_ff,  nxt_phase;
   logic [INTERP_W-1:0] interp_ff, nxt_interp;

   assign trig_rise = sync2_ff && !sync3_ff;

   // pending flags: a new edge wins over the clear at a boundary
   always_comb begin
      nxt_pend_tb   = trig_rise || (pend_tb_ff && !tb_wrap);
      nxt_pend_ref  = trig_rise || (pend_ref_ff && !ref_bound);
      nxt_tb_pulse  = tb_wrap ? pend_tb_ff : tb_pulse_ff;
      nxt_ref_pulse = ref_bound ? pend_ref_ff : ref_pulse_ff;
      // phase code: bit0 is the 500 MHz level, bit1 the 250 MHz level
      nxt_phase     = (tb_wrap && pend_tb_ff) ? q_cnt_nxt : phase_ff;
      // interpolation MSBs: timebase phase scaled to four steps
      nxt_interp    = trig_rise ? INTERP_W'((32'(tb_cnt) * 4) / TB_DIV) : interp_ff;
   end

   // trigger registers; sync1 is read by sync2 only
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sync1_ff     <= 1'b0;
         sync2_ff     <= 1'b0;
         sync3_ff     <= 1'b0;
         pend_tb_ff   <= 1'b0;
         pend_ref_ff  <= 1'b0;
         tb_pulse_ff  <= 1'b0;
         ref_pulse_ff <= 1'b0;
         phase_ff     <= '0;
         interp_ff    <= '0;
      end else begin
         sync1_ff     <= system_trigger_in;
         sync2_ff     <= sync1_ff;
         sync3_ff     <= sync2_ff;
         pend_tb_ff   <= nxt_pend_tb;
         pend_ref_ff  <= nxt_pend_ref;
         tb_pulse_ff  <= nxt_tb_pulse;
         ref_pulse_ff <= nxt_ref_pulse;
         phase_ff     <= nxt_phase;
         interp_ff    <= nxt_interp;
      end
   end

   // output carriers
   assign clocks_out.digitizer_clock         = dig_clk_ff;
   assign clocks_out.timebase_clock          = tb_clk_ff;
   assign clocks_out.reference_quarter_clock = ref_clk_ff;
   assign trig_out.timebase_trigger_pulse    = tb_pulse_ff;
   assign trig_out.reference_trigger_pulse   = ref_pulse_ff;
   assign trig_out.phase_code                = phase_ff;
   assign trig_out.interp_msb                = interp_ff;

   // settle counter for the checks: the first divider periods after reset
   // are short, so the period checks wait one reference period
   localparam int SETTLE_CYC = TB_DIV * REF_DIV;
   localparam int SETTLE_W   = $clog2(SETTLE_CYC + 1);
   logic [SETTLE_W-1:0] settle_ff, nxt_settle;
   logic                settled;

   assign settled = (settle_ff == SETTLE_W'(SETTLE_CYC));

   // settle count, saturating once settled
   always_comb begin
      nxt_settle = settle_ff;
      if (!settled) begin
         nxt_settle = settle_ff + SETTLE_W'(1);
      end
   end

   // settle register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         settle_ff <= '0;
      end else begin
         settle_ff <= nxt_settle;
      end
   end

   sequence s_trig_rise;
      sync2_ff && !sync3_ff;
   endsequence

   sequence s_tb_start;
      $rose(tb_pulse_ff);
   endsequence

   a_tb_div_period: assert property (settled && $rose(tb_clk_ff) |->
      ##10 $rose(tb_clk_ff))
      else $error("timebase clock period is not ten sample ticks");
   a_dig_gate_off: assert property (!run_gate_ff |-> dig_clk_ff == '0)
      else $error("digitizer clock runs while gate is off");
   a_dig_same_edge: assert property ($rose(dig_clk_ff[0]) |->
      $rose(tb_clk_ff) && (dig_clk_ff == '1))
      else $error("digitizer clocks do not start on one timebase edge");
   a_ref_div_four: assert property (settled && $rose(ref_clk_ff[0]) |->
      ##40 $rose(ref_clk_ff[0]))
      else $error("reference clock period is not four timebase periods");
   a_quad_step: assert property (settled && $rose(ref_clk_ff[0]) |->
      ##10 $rose(ref_clk_ff[1]))
      else $error("reference copy one not a quarter period later");
   a_cal_clock_off: assert property (!cal_gate_ff |-> !ref_clk_ff[CAL_COPY])
      else $error("calibrator reference clock runs while disabled");
   a_cal_gate_phase: assert property ($changed(cal_gate_ff) |-> $rose(ref_clk_ff[0]))
      else $error("calibrator gate changed off the reference clock edge");
   a_tb_trig_seen: assert property (s_trig_rise |-> ##[1:11] tb_pulse_ff)
      else $error("no timebase trigger pulse after trigger edge");
   a_tb_pulse_len: assert property (s_tb_start |-> tb_pulse_ff[*8] ##1 tb_pulse_ff[*2])
      else $error("timebase trigger pulse too short");
   a_tb_pulse_edge: assert property (s_tb_start |-> $rose(tb_clk_ff))
      else $error("timebase trigger pulse not on a timebase clock edge");
   a_ref_trig_seen: assert property (s_trig_rise |-> ##[1:41] ref_pulse_ff)
      else $error("no reference trigger pulse after trigger edge");
   a_ref_trig_phase: assert property ($rose(ref_pulse_ff) |-> $rose(ref_clk_ff[0]))
      else $error("reference trigger not aligned to reference clock");
   a_gate_phase: assert property ($changed(run_gate_ff) |-> $rose(ref_clk_ff[0]))
      else $error("run gate changed off the reference clock edge");
   a_phase_code: assert property (s_tb_start |-> phase_ff == q_cnt)
      else $error("phase code does not match divider phase");
   a_interp_cap: assert property (s_trig_rise |=>
      interp_ff == INTERP_W'((32'($past(tb_cnt)) * 4) / TB_DIV))
      else $error("interpolation bits not captured");
   a_sync_chain: assert property (sync2_ff |=> sync3_ff)
      else $error("synchroniser stage did not advance");
   a_reset_quiet: assert property (disable iff (1'b0) rst_in |=>
      !tb_pulse_ff && !ref_pulse_ff && dig_clk_ff == '0)
      else $error("outputs active after reset");
endmodule

// ### tbts_mem_model.sv
// tbts_mem_model: memory controller stand-in counting trigger pulses.
// assumes the block outputs change only on clock_in rising edges.
module tbts_mem_model
   import tbts_pkg::*;
(
   input  wire logic                 clock_in,
   input  wire logic                 rst_in,
   input  wire tbts_pkg::tbts_clocks_t clocks_in,
   input  wire tbts_pkg::tbts_trig_t   trig_in,
   output int                        tb_pulses_out,
   output int                        ref_pulses_out,
   output int                        errors_out
);
   import tbts_pkg::*;
   logic tb_ff, rt_ff, rc_ff;
   int   tb_len, rt_len;
   // count pulses and widths; a ref pulse must open on a ref clock rise
   always @(posedge clock_in) begin
      if (rst_in) begin
         tb_pulses_out = 0;
         ref_pulses_out = 0;
         errors_out = 0;
         tb_len = 0;
         rt_len = 0;
      end else begin
         if (trig_in.timebase_trigger_pulse) tb_len++;
         if (trig_in.timebase_trigger_pulse && !tb_ff) tb_pulses_out++;
         if (!trig_in.timebase_trigger_pulse && tb_ff && tb_len != TB_DIV) errors_out++;
         if (!trig_in.timebase_trigger_pulse) tb_len = 0;
         if (trig_in.reference_trigger_pulse) rt_len++;
         if (trig_in.reference_trigger_pulse && !rt_ff) begin
            ref_pulses_out++;
            // fixed phase lets the controller compensate once
            if (!(clocks_in.reference_quarter_clock[0] && !rc_ff)) errors_out++;
         end
         if (!trig_in.reference_trigger_pulse && rt_ff && rt_len != TB_DIV * REF_DIV) errors_out++;
         if (!trig_in.reference_trigger_pulse) rt_len = 0;
      end
      tb_ff = trig_in.timebase_trigger_pulse;
      rt_ff = trig_in.reference_trigger_pulse;
      rc_ff = clocks_in.reference_quarter_clock[0];
   end
endmodule

// ### timebase_trigger_sync_tb_top.sv
// timebase_trigger_sync_tb_top: self-checking bench of tbts_core.
// assumes clock_in stands for the sample clock; no other clock exists.
module timebase_trigger_sync_tb_top import tbts_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REF_P = TB_DIV * REF_DIV;
   logic         clock_in = 1'h0;
   logic         rst_in = 1'h1;
   logic         system_trigger_in = 1'h0;
   logic         digitizer_run_gate_in = 1'h1;
   logic         calibrator_enable_in = 1'h1;
   tbts_clocks_t clocks_out;
   tbts_trig_t   trig_out;
   int           tb_pulses, ref_pulses, model_errors, exp_ip;
   int           fail_count = 0;
   int           comparisons = 0;
   int           cycles = 0;
   int           first [9];
   int           cnt [9];
   int           hist_ph [4] = '{0, 0, 0, 0};
   int           hist_ip [4] = '{0, 0, 0, 0};

   // clock generator
   always #12.5 clock_in = ~clock_in;

   tbts_core tbts_core_inst (.clock_in(clock_in), .rst_in(rst_in),
      .system_trigger_in(system_trigger_in), .digitizer_run_gate_in(digitizer_run_gate_in),
      .calibrator_enable_in(calibrator_enable_in), .clocks_out(clocks_out), .trig_out(trig_out));
   tbts_mem_model tbts_mem_model_inst (.clock_in(clock_in), .rst_in(rst_in),
      .clocks_in(clocks_out), .trig_in(trig_out), .tb_pulses_out(tb_pulses),
      .ref_pulses_out(ref_pulses), .errors_out(model_errors));

   // compare one value and log a mismatch
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask

   // wait n edges, then settle past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask

   // count rises of each clock output bit over n cycles
   task automatic sample_rises(input int n);
      logic [8:0] was;
      was = clocks_out;
      for (int j = 0; j < 9; j++) begin
         cnt[j] = 0;
         first[j] = -1;
      end
      for (int i = 0; i < n; i++) begin
         cyc(1);
         for (int j = 0; j < 9; j++) begin
            if (clocks_out[j] && !was[j]) begin
               if (cnt[j] == 0) first[j] = i;
               cnt[j]++;
            end
         end
         was = clocks_out;
      end
   endtask

   // outputs idle while reset is held
   task automatic test_reset();
      check("clocks in reset", 0, clocks_out);
      check("triggers in reset", 0, trig_out);
      rst_in = 1'h0;
      $display("test reset done");
   endtask

   // division ratios, quadrature lag and common digitizer edge
   task automatic test_divide();
      cyc(90);
      sample_rises(2 * REF_P);
      check("timebase rises", 2 * REF_DIV, cnt[4]);
      for (int k = 0; k < 4; k++) begin
         check("digitizer rises", 2 * REF_DIV, cnt[5 + k]);
         check("digitizer edge", first[5], first[5 + k]);
         check("reference rises", 2, cnt[k]);
         check("reference lag", TB_DIV * k, (first[k] - first[0] + REF_P) % REF_P);
      end
      $display("test divide done");
   endtask

   // run gate and calibrator enable switch their clocks off
   task automatic test_gates();
      digitizer_run_gate_in = 1'h0;
      calibrator_enable_in = 1'h0;
      cyc(2 * REF_P);
      sample_rises(2 * REF_P);
      check("gated digitizer rises", 0, cnt[5] + cnt[6] + cnt[7] + cnt[8]);
      check("calibrator copy rises", 0, cnt[3]);
      check("copy 0 rises", 2, cnt[0]);
      digitizer_run_gate_in = 1'h1;
      calibrator_enable_in = 1'h1;
      cyc(2 * REF_P);
      $display("test gates done");
   endtask

   // trigger at every offset of the reference period
   task automatic test_sweep();
      logic was;
      for (int k = 0; k < REF_P; k++) begin
         was = 1'h1;
         for (int w = 0; w < REF_P + 2 && !(clocks_out[0] && !was); w++) begin
            was = clocks_out[0];
            cyc(1);
         end
         cyc(k);
         system_trigger_in = 1'h1;
         cyc(2);
         system_trigger_in = 1'h0;
         cyc(3 * REF_P);
         hist_ph[trig_out.phase_code]++;
         hist_ip[trig_out.interp_msb]++;
      end
      check("timebase pulses", REF_P, tb_pulses);
      check("reference pulses", REF_P, ref_pulses);
      check("pulse faults", 0, model_errors);
      for (int v = 0; v < 4; v++) begin
         exp_ip = 0;
         for (int c = 0; c < TB_DIV; c++) exp_ip += (c * 4 / TB_DIV == v) ? REF_DIV : 0;
         check("phase code count", REF_P / 4, hist_ph[v]);
         check("interpolation count", exp_ip, hist_ip[v]);
      end
      $display("test sweep done");
   endtask

   // print counts and the verdict, then stop
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   // main sequence
   initial begin
      cyc(10);
      test_reset();
      test_divide();
      test_gates();
      test_sweep();
      print_verdict();
   end
endmodule
